//--- src/brw_cfg.svh
`ifndef BRW_CFG_SVH
`define BRW_CFG_SVH
// Summary of operation
// R01: After any reset the timer is passive and never resets the system.
// R02: First trigger request after reset moves the timer from passive to active.
// R03: Software selects the timeout from four periods: 2, 10, 50 or 255 seconds.
// R04: When active, a gap between triggers longer than the period causes reset.
// R05: Once active, the timer stays active until reset; software cannot disable.
// R06: A new timeout selection is accepted at any time and used from then on.
// R07: Software triggers more often than the selected period to avoid a reset.
// R08: Handle button gives one short reset pulse; rearms only after handle closes.
// R09: Driving the backplane push-reset low resets the board like the handle button.
// R10: Power-on reset is held while any monitored supply is out of specification.
// R11: By default the health LED lights only when supplies good and reset released.
// R12: Every system reset returns the health LED to its default health mode.
// R13: On request the LED goes to software control until the next system reset.
// R14: Manual inputs are debounced and each event stretched to a fixed reset width.

//--------------------------------------------------------------
// Timing
//--------------------------------------------------------------
`define BRW_CLK_HZ 125000000
`define BRW_TICK_MS 1
`define BRW_TICK_CYC (`BRW_CLK_HZ / 1000 * `BRW_TICK_MS)
`define BRW_SEL_2S 2'h0
`define BRW_SEL_10S 2'h1
`define BRW_SEL_50S 2'h2
`define BRW_SEL_255S 2'h3
`define BRW_T_2S_MS 2000
`define BRW_T_10S_MS 10000
`define BRW_T_50S_MS 50000
`define BRW_T_255S_MS 255000
`define BRW_DEB_MS 10
`define BRW_PULSE_MS 100
`define BRW_POR_MS 200
`endif

//--- src/brw_debounce.sv
`timescale 1ns/10ps
`include "brw_cfg.svh"
// Synchronises a pin and accepts a new level only after it holds steady.
module brw_debounce import brw_pkg::*; #(
	parameter int STABLE_TICKS = `BRW_DEB_MS
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic pin_i,
	output logic level_o
);
	localparam int CW = $clog2(STABLE_TICKS + 1);
	logic meta;
	logic sync;
	logic [CW-1:0] count;
	wire differs = sync != level_o;
	wire settled = count == CW'(STABLE_TICKS);
	// Two-stage synchroniser; meta only feeds sync
	always_ff @(posedge clock_i) begin
		meta <= pin_i;
		sync <= meta;
	end
	// Count ticks of disagreement; bounce restarts the count
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !differs) begin
			count <= '0;
		end else if (tick_i) begin
			count <= count + CW'(1);
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			level_o <= 1'b0;
		end else if (differs && settled) begin
			level_o <= sync;
		end
	end
endmodule : brw_debounce

//--- src/brw_pkg.sv
package brw_pkg;
	typedef enum logic [1:0] {BRW_PASSIVE, BRW_ACTIVE} brw_wd_state_t;
	// Software service request bundle
	typedef struct packed {
		logic trigger;
		logic sel_we;
		logic [1:0] sel;
		logic led_take;
		logic led_value;
	} brw_sw_req_t;
	// Raw board pins
	typedef struct packed {
		logic supply_1v8_ok;
		logic supply_3v3_ok;
		logic supply_5v_ok;
		logic handle_pressed;
		logic handle_closed;
		logic ext_push_reset_n;
	} brw_pins_t;
endpackage : brw_pkg

//--- src/brw_top.sv
`timescale 1ns/10ps
`include "brw_cfg.svh"
module brw_top import brw_pkg::*; #(
	parameter int TICK_CYC = `BRW_TICK_CYC,
	parameter int T2_MS = `BRW_T_2S_MS,
	parameter int T10_MS = `BRW_T_10S_MS,
	parameter int T50_MS = `BRW_T_50S_MS,
	parameter int T255_MS = `BRW_T_255S_MS,
	parameter int DEB_MS = `BRW_DEB_MS,
	parameter int PULSE_MS = `BRW_PULSE_MS,
	parameter int POR_MS = `BRW_POR_MS
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire brw_pins_t pins_i,
	input wire brw_sw_req_t sw_i,
	output logic system_reset_n_o,
	output logic board_healthy_led_o,
	output logic timer_active_o,
	output logic [1:0] timer_sel_o,
	output logic led_soft_o
);
	//--------------------------------------------------------------
	// Millisecond tick divider
	//--------------------------------------------------------------
	localparam int DW = $clog2(TICK_CYC + 1);
	logic [DW-1:0] div;
	logic tick;
	wire div_end = div == DW'(TICK_CYC - 1);
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			div <= '0;
			tick <= 1'b0;
		end else begin
			div <= div_end ? '0 : div + DW'(1);
			tick <= div_end;
		end
	end

	//--------------------------------------------------------------
	// Supply monitor and power-on reset
	//--------------------------------------------------------------
	logic [2:0] sup_meta;
	logic [2:0] sup_sync;
	wire all_good = &sup_sync;
	// Supply pins are asynchronous to the clock
	always_ff @(posedge clock_i) begin
		sup_meta <= {pins_i.supply_1v8_ok, pins_i.supply_3v3_ok, pins_i.supply_5v_ok};
		sup_sync <= sup_meta;
	end
	localparam int PW = $clog2(POR_MS + 1);
	logic [PW-1:0] por_cnt;
	logic por_active;
	wire por_done = por_cnt == PW'(POR_MS);
	// Any bad supply restarts the hold time, so the reset covers brownouts too
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !all_good) begin
			por_cnt <= '0; // R10
			por_active <= 1'b1; // R10
		end else begin
			if (tick && !por_done) begin
				por_cnt <= por_cnt + PW'(1);
			end
			por_active <= !por_done;
		end
	end

	//--------------------------------------------------------------
	// Manual reset sources
	//--------------------------------------------------------------
	logic handle_lvl;
	logic closed_lvl;
	logic push_lvl;
	brw_debounce #(.STABLE_TICKS(DEB_MS)) u_deb_handle (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.pin_i(pins_i.handle_pressed),
		.level_o(handle_lvl)
	); // R14
	brw_debounce #(.STABLE_TICKS(DEB_MS)) u_deb_closed (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.pin_i(pins_i.handle_closed),
		.level_o(closed_lvl)
	);
	brw_debounce #(.STABLE_TICKS(DEB_MS)) u_deb_push (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.pin_i(!pins_i.ext_push_reset_n),
		.level_o(push_lvl)
	); // R09
	// Armed flag lives across the system reset it causes, so only the
	// handle re-closing rearms it; that is what makes the pulse single
	logic handle_armed;
	logic handle_q;
	logic push_q;
	wire handle_evt = handle_lvl && !handle_q && handle_armed;
	wire push_evt = push_lvl && !push_q; // R09
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			handle_armed <= 1'b1;
			handle_q <= 1'b0;
			push_q <= 1'b0;
		end else begin
			handle_q <= handle_lvl;
			push_q <= push_lvl;
			if (handle_evt) begin
				handle_armed <= 1'b0; // R08
			end else if (closed_lvl && !handle_lvl) begin
				handle_armed <= 1'b1; // R08
			end
		end
	end

	//--------------------------------------------------------------
	// Reset pulse stretcher
	//--------------------------------------------------------------
	// One spare count: the first tick may come a cycle after the load, so
	// loading PULSE_MS + 1 keeps the pulse at least PULSE_MS ticks wide
	localparam int SW = $clog2(PULSE_MS + 2);
	logic [SW-1:0] pulse_cnt;
	wire pulse_busy = pulse_cnt != '0;
	logic wd_fire;
	wire start_pulse = handle_evt || push_evt || wd_fire;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pulse_cnt <= '0;
		end else if (start_pulse) begin
			pulse_cnt <= SW'(PULSE_MS + 1); // R14
		end else if (tick && pulse_busy) begin
			pulse_cnt <= pulse_cnt - SW'(1);
		end
	end
	// Internal system reset, shared by timer and LED logic
	wire sys_rst = por_active || pulse_busy || start_pulse;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			system_reset_n_o <= 1'b0;
		end else begin
			system_reset_n_o <= !sys_rst; // R10
		end
	end

	//--------------------------------------------------------------
	// Supervisor timer
	//--------------------------------------------------------------
	function automatic logic [17:0] period_ms(input logic [1:0] sel);
		case (sel)
			`BRW_SEL_2S: period_ms = 18'(T2_MS);
			`BRW_SEL_10S: period_ms = 18'(T10_MS);
			`BRW_SEL_50S: period_ms = 18'(T50_MS);
			default: period_ms = 18'(T255_MS);
		endcase
	endfunction : period_ms
	brw_wd_state_t wd_state;
	logic [17:0] wd_cnt;
	wire wd_live = wd_state == BRW_ACTIVE;
	wire wd_expired = wd_live && tick && wd_cnt >= period_ms(timer_sel_o); // R04
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || sys_rst) begin
			wd_state <= BRW_PASSIVE; // R01
			wd_cnt <= '0;
			wd_fire <= 1'b0;
		end else begin
			wd_fire <= wd_expired; // R04
			case (wd_state)
				BRW_PASSIVE: begin
					if (sw_i.trigger) begin
						wd_state <= BRW_ACTIVE; // R02
					end
					wd_cnt <= '0;
				end
				BRW_ACTIVE: begin
					// No exit path: only reset leaves this state
					if (sw_i.trigger) begin
						wd_cnt <= '0;
					end else if (tick && !wd_expired) begin
						wd_cnt <= wd_cnt + 18'(1); // R05
					end
				end
				default: wd_state <= BRW_PASSIVE;
			endcase
		end
	end
	// Selection survives manual resets only through software rewriting it
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || sys_rst) begin
			timer_sel_o <= `BRW_SEL_255S;
		end else if (sw_i.sel_we) begin
			timer_sel_o <= sw_i.sel; // R06 R03
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			timer_active_o <= 1'b0;
		end else begin
			timer_active_o <= wd_live && !sys_rst;
		end
	end

	//--------------------------------------------------------------
	// Health LED
	//--------------------------------------------------------------
	logic led_sw_val;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || sys_rst) begin
			led_soft_o <= 1'b0; // R12
			led_sw_val <= 1'b0;
		end else begin
			if (sw_i.led_take) begin
				led_soft_o <= 1'b1; // R13
			end
			if (sw_i.led_take || led_soft_o) begin
				led_sw_val <= sw_i.led_value;
			end
		end
	end
	wire led_next = led_soft_o ? led_sw_val : (all_good && !sys_rst); // R11
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			board_healthy_led_o <= 1'b0;
		end else begin
			board_healthy_led_o <= led_next;
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	// Cycles the stretcher has been busy, so the width check needs no long repetition
	logic [31:0] busy_cycles;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !pulse_busy) begin
			busy_cycles <= '0;
		end else begin
			busy_cycles <= busy_cycles + 32'h1;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// Supervisor timer states
	passive_after_reset_a: assert property (sys_rst |=> !wd_live) // R01
		else $error("timer not passive after reset");
	passive_no_fire_a: assert property (!wd_live |=> !wd_fire) // R01
		else $error("passive timer fired");
	arm_on_trigger_a: assert property (!wd_live && !sys_rst && sw_i.trigger |=> wd_live) // R02
		else $error("trigger did not arm timer");
	stays_active_a: assert property (wd_live && !sys_rst |=> wd_live) // R05
		else $error("timer left active state");
	active_flag_a: assert property (wd_live && !sys_rst |=> timer_active_o) // R05
		else $error("active flag not shown");

	// Expiry path; a reset from another source in the same cycle already covers it
	timeout_fire_a: assert property ( // R04
		wd_expired && !sys_rst |=> wd_fire ##1 !system_reset_n_o)
		else $error("expiry did not reset system");
	sel_update_a: assert property (sw_i.sel_we && !sys_rst |=> timer_sel_o == $past(sw_i.sel)) // R06
		else $error("selection not taken");
	sel_default_a: assert property (sys_rst |=> timer_sel_o == `BRW_SEL_255S) // R03
		else $error("selection not restored");

	// Reset sources and pulse width
	supply_hold_a: assert property (!all_good |=> ##1 !system_reset_n_o) // R10
		else $error("reset released with bad supply");
	handle_single_a: assert property (handle_evt |=> !handle_armed) // R08
		else $error("handle not disarmed");
	rearm_hold_a: assert property ( // R08
		!handle_armed && !(closed_lvl && !handle_lvl) |=> !handle_armed)
		else $error("handle rearmed while open");
	push_reset_a: assert property (push_evt |=> !system_reset_n_o) // R09
		else $error("push reset ignored");
	pulse_width_a: assert property ( // R14
		$fell(pulse_busy) |-> busy_cycles >= 32'(PULSE_MS * TICK_CYC))
		else $error("reset pulse too short");

	// Health LED
	led_default_a: assert property (!led_soft_o && sys_rst |=> !board_healthy_led_o) // R11
		else $error("led lit during reset");
	led_dark_a: assert property (!led_soft_o && !all_good |=> !board_healthy_led_o) // R11
		else $error("led lit with bad supply");
	led_mode_a: assert property (sys_rst |=> !led_soft_o) // R12
		else $error("led mode kept over reset");
	led_take_a: assert property (sw_i.led_take && !sys_rst |=> led_soft_o) // R13
		else $error("led not handed to software");
	led_keep_a: assert property (led_soft_o && !sys_rst |=> led_soft_o) // R13
		else $error("led left software control");

	//--------------------------------------------------------------
	// Cover points
	//--------------------------------------------------------------
	cover_arm_c: cover property (wd_state == BRW_PASSIVE ##1 wd_live);
	cover_fire_c: cover property (wd_fire);
	cover_handle_c: cover property (handle_evt);
	cover_push_c: cover property (push_evt);
	cover_led_c: cover property (led_soft_o && sw_i.led_value);
endmodule : brw_top

//--- test/brw_host_model.sv
`timescale 1ns/10ps
// -----------------------------------
// Host software and backplane driver
// -----------------------------------
module brw_host_model import brw_pkg::*; (
	input wire logic clock_i,
	output brw_pins_t pins_o,
	output brw_sw_req_t sw_o
);
	// Board side starts idle: supplies good, handle closed and released, push line up
	logic [2:0] supply_ok = 3'h7;
	logic pressed = 1'b0;
	logic closed = 1'b1;
	logic push_n = 1'b1;
	// Software side starts quiet; the LED value is a level and outlives its call
	logic trigger = 1'b0;
	logic sel_we = 1'b0;
	logic [1:0] sel = 2'h0;
	logic led_take = 1'b0;
	logic led_value = 1'b0;
	// Every field is driven by its own variable or its own supply_ok bit, so each one can be exercised
	assign pins_o = '{supply_ok[2], supply_ok[1], supply_ok[0], pressed, closed, push_n};
	assign sw_o = '{trigger, sel_we, sel, led_take, led_value};
	// Pin levels change just after an edge
	task automatic set_supply(input logic [2:0] ok);
		@(posedge clock_i);
		supply_ok <= ok;
	endtask : set_supply
	task automatic set_handle(input logic press, input logic close);
		@(posedge clock_i);
		pressed <= press;
		closed <= close;
	endtask : set_handle
	// Push line low resets the board; held low it must still give one pulse
	task automatic set_push(input logic level_n);
		@(posedge clock_i);
		push_n <= level_n;
	endtask : set_push
	// Service calls are one-cycle strobes
	task automatic trigger_req();
		@(posedge clock_i);
		trigger <= 1'b1;
		@(posedge clock_i);
		trigger <= 1'b0;
	endtask : trigger_req
	task automatic select_req(input logic [1:0] s);
		@(posedge clock_i);
		sel_we <= 1'b1;
		sel <= s;
		@(posedge clock_i);
		sel_we <= 1'b0;
	endtask : select_req
	task automatic led_req(input logic value);
		@(posedge clock_i);
		led_take <= 1'b1;
		led_value <= value;
		@(posedge clock_i);
		led_take <= 1'b0;
	endtask : led_req
endmodule : brw_host_model

//--- test/brw_top_tb_top.sv
`timescale 1ns/10ps
module brw_top_tb_top import brw_pkg::*; ;
	// ---------------------------------
	// Clock, design and partner
	// ---------------------------------
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	brw_pins_t pins;
	brw_sw_req_t sw;
	logic rst_o, led_o, act_o, soft_o;
	logic [1:0] sel_o;
	int mismatches = 0;
	int samples_checked = 0;
	int per[4] = '{4, 8, 12, 16};
	int n;
	always #4 clock_i = ~clock_i;
	// Short counts keep the run small; one ms is four cycles here
	brw_top #(.TICK_CYC(4), .T2_MS(4), .T10_MS(8), .T50_MS(12), .T255_MS(16),
		.DEB_MS(2), .PULSE_MS(3), .POR_MS(3)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.pins_i(pins), .sw_i(sw), .system_reset_n_o(rst_o), .board_healthy_led_o(led_o),
		.timer_active_o(act_o), .timer_sel_o(sel_o), .led_soft_o(soft_o));
	brw_host_model host (.clock_i(clock_i), .pins_o(pins), .sw_o(sw));
	// ---------------------------------
	// Helpers
	// ---------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	task automatic cyc(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask : cyc
	// Bounded wait on the board reset; a hang ends the run
	task automatic wait_rst(input logic lvl, input int lim, output int k);
		k = 0;
		while (rst_o !== lvl) begin
			cyc(1);
			k++;
			if (k > lim) begin
				check("reset_wait", rst_o, lvl);
				close_out();
			end
		end
	endtask : wait_rst
	// ---------------------------------
	// Scenarios
	// ---------------------------------
	task automatic t_boot();
		check("led_in_reset", led_o, 0);
		wait_rst(1, 100, n);
		check("act", act_o, 0);
		check("sel", sel_o, 3);
		check("led", led_o, 1);
		cyc(100);
		check("passive_rst", rst_o, 1);
		$display("boot done");
	endtask : t_boot
	// Arm, reselect while active, let each period run out
	task automatic t_expiry();
		for (int i = 0; i < 4; i++) begin
			host.trigger_req();
			host.select_req(2'(i));
			cyc(1);
			check("sel", sel_o, 8'(i));
			check("act", act_o, 1);
			wait_rst(0, per[i] * 4 + 20, n);
			check("expiry", n >= per[i] * 4 - 8 && n <= per[i] * 4 + 8, 1);
			wait_rst(1, 100, n);
			check("act_after", act_o, 0);
		end
		$display("expiry done");
	endtask : t_expiry
	// Triggers closer than the period keep the board running
	task automatic t_alive();
		host.trigger_req();
		host.select_req(2'h0);
		repeat (8) begin
			host.trigger_req();
			cyc(10);
			check("alive_rst", rst_o, 1);
			check("alive_act", act_o, 1);
		end
		// Triggers stop: the shortest period must run out and leave it passive
		wait_rst(0, 40, n);
		check("alive_late", n >= 4 && n <= 16, 1);
		wait_rst(1, 100, n);
		check("alive_passive", act_o, 0);
		$display("alive done");
	endtask : t_alive
	task automatic t_led();
		host.led_req(1'b0);
		cyc(2);
		check("soft", soft_o, 1);
		check("led_off", led_o, 0);
		host.led_req(1'b1);
		cyc(2);
		check("led_on", led_o, 1);
		$display("led done");
	endtask : t_led
	// Push line held low gives one stretched pulse only
	task automatic t_push();
		host.set_push(1'b0);
		wait_rst(0, 40, n);
		wait_rst(1, 60, n);
		check("width", n >= 12, 1);
		cyc(80);
		check("single", rst_o, 1);
		check("soft", soft_o, 0);
		check("act", act_o, 0);
		host.set_push(1'b1);
		$display("push done");
	endtask : t_push
	// Second press before the handle is closed again must be ignored
	task automatic t_handle();
		host.set_handle(1'b1, 1'b1);
		wait_rst(0, 40, n);
		wait_rst(1, 60, n);
		host.set_handle(1'b0, 1'b0);
		cyc(20);
		host.set_handle(1'b1, 1'b0);
		cyc(60);
		check("no_rearm", rst_o, 1);
		host.set_handle(1'b0, 1'b1);
		cyc(20);
		host.set_handle(1'b1, 1'b1);
		wait_rst(0, 40, n);
		check("rearm", rst_o, 0);
		host.set_handle(1'b0, 1'b1);
		wait_rst(1, 60, n);
		$display("handle done");
	endtask : t_handle
	task automatic t_supply();
		for (int b = 0; b < 3; b++) begin
			host.set_supply(3'h7 & ~(3'h1 << b));
			wait_rst(0, 20, n);
			check("led_bad", led_o, 0);
			cyc(40);
			check("por_held", rst_o, 0);
			host.set_supply(3'h7);
			wait_rst(1, 40, n);
			check("led_good", led_o, 1);
		end
		$display("supply done");
	endtask : t_supply
	// ---------------------------------
	// Main sequence
	// ---------------------------------
	initial begin
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		cyc(1);
		t_boot();
		t_expiry();
		t_alive();
		t_led();
		t_push();
		t_handle();
		t_supply();
		close_out();
	end
	// Catch-all guard against a stalled sequence
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
endmodule : brw_top_tb_top
